// [rtl/mfa_pkg.sv]
package mfa_pkg;

    // register byte offsets on the Avalon-MM slave
    localparam logic [3:0] OFS_LIVE      = 4'h0;
    localparam logic [3:0] OFS_IRQ_STAT  = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK  = 4'h8;
    localparam logic [3:0] OFS_CTRL      = 4'hC;

    // live register field positions
    localparam int LIVE_OPEN_POS   = 0;
    localparam int LIVE_SHORT_POS  = 1;
    localparam int LIVE_TEMP_POS   = 2;
    localparam int LIVE_PKT_POS    = 3;
    localparam int LIVE_HWMODE_POS = 4;
    localparam int LIVE_VALID_POS  = 5;
    localparam int LIVE_FAULT_POS  = 6;
    localparam int LIVE_OCPIN_POS  = 7;

    // irq status and mask layout (same for both)
    localparam int IRQ_OPEN_POS  = 0;
    localparam int IRQ_SHORT_POS = 1;
    localparam int IRQ_TEMP_POS  = 2;
    localparam int IRQ_PKT_POS   = 3;
    localparam int IRQ_W         = 4;

    // control register bits, both self-clearing strobes
    localparam int CTRL_PKT_CLR_POS  = 0;
    localparam int CTRL_SOFT_RST_POS = 1;

    // analog fault comparator inputs
    localparam int FLT_W         = 3;
    localparam int FLT_OPEN_IDX  = 0;
    localparam int FLT_SHORT_IDX = 1;
    localparam int FLT_TEMP_IDX  = 2;

    // reset values
    localparam logic [IRQ_W-1:0] IRQ_STAT_RST = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam logic [31:0]      RDATA_RST    = 32'h0000_0000;

    // strap capture delay after reset release, in clock cycles
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

    typedef struct packed {
        logic                 strap_s1;
        logic                 strap_s2;
        logic                 prst_s1;
        logic                 prst_s2;
        logic [FLT_W-1:0]     flt_s1;
        logic [FLT_W-1:0]     flt_s2;
        logic [FLT_W-1:0]     flt_prev;
        logic [1:0]           settle_cnt;
        logic                 mode_valid;
        logic                 hw_mode;
        logic                 pkt_err;
        logic [IRQ_W-1:0]     irq_stat;
        logic [IRQ_W-1:0]     irq_mask;
        logic                 ack;
        logic [31:0]          rdata;
        logic                 fault_oe;
        logic                 oc_oe;
        logic                 irq;
    } mfa_state_t;

    // reset sync idles high like its pin, so leaving reset is no pin reset
    localparam mfa_state_t STATE_RST = '{
        strap_s1:   1'b0,
        strap_s2:   1'b0,
        prst_s1:    1'b1,
        prst_s2:    1'b1,
        flt_s1:     3'h0,
        flt_s2:     3'h0,
        flt_prev:   3'h0,
        settle_cnt: 2'h0,
        mode_valid: 1'b0,
        hw_mode:    1'b0,
        pkt_err:    1'b0,
        irq_stat:   IRQ_STAT_RST,
        irq_mask:   IRQ_MASK_RST,
        ack:        1'b0,
        rdata:      RDATA_RST,
        fault_oe:   1'b0,
        oc_oe:      1'b0,
        irq:        1'b0
    };

endpackage

// [rtl/mfa_alerts.sv]
`timescale 1ns/1ps
`default_nettype none

module mfa_alerts (
    input  wire logic        CLK_SYS,             // 100 MHz system clock
    input  wire logic        NRST,                // async reset, active low
    input  wire logic        CONTROL_MODE_STRAP,  // pin strap, 1 = hardware control
    input  wire logic        PART_RESET_N,        // pin reset request, active low
    input  wire logic [2:0]  FAULT_DET,           // analog comparators: open, short, overtemp
    input  wire logic        PACKET_CHECK_ERR,    // one-cycle pulse from serial interface
    input  wire logic [3:0]  AVS_ADDRESS,         // byte address
    input  wire logic        AVS_READ,            // read request
    input  wire logic        AVS_WRITE,           // write request
    input  wire logic [31:0] AVS_WRITEDATA,       // write data
    input  wire logic [3:0]  AVS_BYTEENABLE,      // byte lanes
    output logic      [31:0] AVS_READDATA,        // read data
    output logic             AVS_WAITREQUEST,     // stall
    output logic             IRQ,                 // level interrupt
    output logic             FAULT_ALERT_O,       // shared alert pin drive value
    output logic             FAULT_ALERT_OE,      // shared alert pin pull enable
    output logic             OPEN_CIRCUIT_ALERT_N_O,  // dedicated pin drive value
    output logic             OPEN_CIRCUIT_ALERT_N_OE  // dedicated pin pull enable
);

    mfa_pkg::mfa_state_t st_q;
    mfa_pkg::mfa_state_t st_d;

    logic       req;
    logic       take;
    logic       wr_take;
    logic       soft_rst;
    logic       part_rst;
    logic [2:0] flt_rise;
    logic [3:0] irq_evt;
    logic [3:0] irq_clr;
    logic       shared_cond;
    logic       oc_cond;
    logic [7:0] live;
    logic       hit_stat;
    logic       hit_mask;
    logic       hit_ctrl;
    logic       pkt_clr;

    assign req      = AVS_READ | AVS_WRITE;
    assign take     = req & st_q.ack;
    assign wr_take  = take & AVS_WRITE & AVS_BYTEENABLE[0];
    assign soft_rst = wr_take && (AVS_ADDRESS == mfa_pkg::OFS_CTRL) &&
                      AVS_WRITEDATA[mfa_pkg::CTRL_SOFT_RST_POS];
    assign part_rst = ~st_q.prst_s2;

    // address decode, shared by the logic and its checks
    assign hit_stat = AVS_ADDRESS == mfa_pkg::OFS_IRQ_STAT;
    assign hit_mask = AVS_ADDRESS == mfa_pkg::OFS_IRQ_MASK;
    assign hit_ctrl = AVS_ADDRESS == mfa_pkg::OFS_CTRL;
    assign pkt_clr  = wr_take && hit_ctrl && AVS_WRITEDATA[mfa_pkg::CTRL_PKT_CLR_POS];

    // one wait cycle, then the answer; the request is never left hanging
    assign AVS_WAITREQUEST = req & ~st_q.ack;
    assign AVS_READDATA    = st_q.rdata;
    assign IRQ             = st_q.irq;

    // open-drain: the value driven is always low, only the enable moves
    assign FAULT_ALERT_O          = 1'b0;
    assign OPEN_CIRCUIT_ALERT_N_O = 1'b0;
    assign FAULT_ALERT_OE         = st_q.fault_oe;
    assign OPEN_CIRCUIT_ALERT_N_OE = st_q.oc_oe;

    assign flt_rise = st_q.flt_s2 & ~st_q.flt_prev;
    assign irq_evt  = {PACKET_CHECK_ERR, flt_rise};
    assign irq_clr  = (wr_take && (AVS_ADDRESS == mfa_pkg::OFS_IRQ_STAT)) ?
                      AVS_WRITEDATA[mfa_pkg::IRQ_W-1:0] : 4'h0;

    // mapping of conditions onto the two pins per control mode
    always_comb begin
        if (!st_q.mode_valid) begin
            shared_cond = 1'b0;
            oc_cond     = 1'b0;
        end else if (st_q.hw_mode) begin
            shared_cond = st_q.flt_s2[mfa_pkg::FLT_TEMP_IDX];
            oc_cond     = st_q.flt_s2[mfa_pkg::FLT_OPEN_IDX];
        end else begin
            shared_cond = (|st_q.flt_s2) | st_q.pkt_err;
            oc_cond     = 1'b0;
        end
    end

    always_comb begin
        live = 8'h00;
        live[mfa_pkg::LIVE_OPEN_POS]   = st_q.flt_s2[mfa_pkg::FLT_OPEN_IDX];
        live[mfa_pkg::LIVE_SHORT_POS]  = st_q.flt_s2[mfa_pkg::FLT_SHORT_IDX];
        live[mfa_pkg::LIVE_TEMP_POS]   = st_q.flt_s2[mfa_pkg::FLT_TEMP_IDX];
        live[mfa_pkg::LIVE_PKT_POS]    = st_q.pkt_err;
        live[mfa_pkg::LIVE_HWMODE_POS] = st_q.hw_mode;
        live[mfa_pkg::LIVE_VALID_POS]  = st_q.mode_valid;
        live[mfa_pkg::LIVE_FAULT_POS]  = st_q.fault_oe;
        live[mfa_pkg::LIVE_OCPIN_POS]  = st_q.oc_oe;
    end

    always_comb begin
        st_d = st_q;

        // pins from outside the clock domain, two stages each
        st_d.strap_s1 = CONTROL_MODE_STRAP;
        st_d.strap_s2 = st_q.strap_s1;
        st_d.prst_s1  = PART_RESET_N;
        st_d.prst_s2  = st_q.prst_s1;
        st_d.flt_s1   = FAULT_DET;
        st_d.flt_s2   = st_q.flt_s1;
        st_d.flt_prev = st_q.flt_s2;

        // strap taken once, after the sync chain has filled since reset
        if (!st_q.mode_valid) begin
            if (st_q.settle_cnt == mfa_pkg::STRAP_SETTLE_CYC) begin
                st_d.mode_valid = 1'b1;
                st_d.hw_mode    = st_q.strap_s2;
            end else begin
                st_d.settle_cnt = st_q.settle_cnt + 2'h1;
            end
        end

        // packet-check error holds the shared alert in software mode until software clears it
        if (PACKET_CHECK_ERR) begin
            st_d.pkt_err = 1'b1;
        end else if (pkt_clr) begin
            st_d.pkt_err = 1'b0;
        end

        // set wins over a clear landing in the same cycle
        st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_evt;
        if (wr_take && (AVS_ADDRESS == mfa_pkg::OFS_IRQ_MASK)) begin
            st_d.irq_mask = AVS_WRITEDATA[mfa_pkg::IRQ_W-1:0];
        end
        st_d.irq = |(st_q.irq_stat & st_q.irq_mask);

        st_d.fault_oe = shared_cond;
        st_d.oc_oe    = oc_cond;

        // bus: ack raised one cycle after request, dropped after the take
        st_d.ack = req & ~st_q.ack;
        if (req && !st_q.ack) begin
            case (AVS_ADDRESS)
                mfa_pkg::OFS_LIVE:     st_d.rdata = {24'h000000, live};
                mfa_pkg::OFS_IRQ_STAT: st_d.rdata = {28'h0000000, st_q.irq_stat};
                mfa_pkg::OFS_IRQ_MASK: st_d.rdata = {28'h0000000, st_q.irq_mask};
                default:               st_d.rdata = mfa_pkg::RDATA_RST;
            endcase
        end

        // pin or software reset: back to power-on state, strap read anew
        if (part_rst || soft_rst) begin
            st_d          = mfa_pkg::STATE_RST;
            st_d.strap_s1 = CONTROL_MODE_STRAP;
            st_d.strap_s2 = st_q.strap_s1;
            st_d.prst_s1  = PART_RESET_N;
            st_d.prst_s2  = st_q.prst_s1;
            st_d.flt_s1   = FAULT_DET;
            st_d.flt_s2   = st_q.flt_s1;
            st_d.ack      = st_q.ack ? 1'b0 : req;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            st_q <= mfa_pkg::STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    logic rst_now;
    assign rst_now = part_rst | soft_rst;

    AST_STRAP_CAPTURE: assert property (
        $rose(st_q.mode_valid) |-> st_q.hw_mode == $past(st_q.strap_s2))
        else $error("mode not taken from strap");

    AST_RESET_CLEARS: assert property (
        rst_now |=> !st_q.mode_valid && !FAULT_ALERT_OE && !OPEN_CIRCUIT_ALERT_N_OE &&
                    st_q.irq_mask == 4'h0 && st_q.irq_stat == 4'h0 && !st_q.pkt_err)
        else $error("reset left state behind");

    AST_SW_SHARED: assert property (
        st_q.mode_valid && !st_q.hw_mode && ((|st_q.flt_s2) || st_q.pkt_err) && !rst_now
        |=> FAULT_ALERT_OE)
        else $error("software mode fault not signalled");

    AST_OPEN_DRAIN: assert property (
        !FAULT_ALERT_O && !OPEN_CIRCUIT_ALERT_N_O)
        else $error("alert pin driven high");

    AST_HW_TEMP_ONLY: assert property (
        st_q.mode_valid && st_q.hw_mode && !rst_now
        |=> FAULT_ALERT_OE == $past(st_q.flt_s2[mfa_pkg::FLT_TEMP_IDX]))
        else $error("hardware shared alert not overtemp only");

    AST_HW_OPEN: assert property (
        st_q.mode_valid && st_q.hw_mode && st_q.flt_s2[mfa_pkg::FLT_OPEN_IDX] && !rst_now
        |=> OPEN_CIRCUIT_ALERT_N_OE)
        else $error("open circuit pin not pulled");

    AST_SW_OC_IDLE: assert property (
        !st_q.hw_mode |=> !OPEN_CIRCUIT_ALERT_N_OE)
        else $error("dedicated pin driven in software mode");

    AST_RELEASE: assert property (
        !shared_cond && !oc_cond |=> !FAULT_ALERT_OE && !OPEN_CIRCUIT_ALERT_N_OE)
        else $error("alert held without condition");

    AST_WAIT_BOUND: assert property (
        req |-> ##[0:1] !AVS_WAITREQUEST)
        else $error("bus request not answered");

    AST_IRQ_LEVEL: assert property (
        |(st_q.irq_stat & st_q.irq_mask) && !rst_now |=> IRQ)
        else $error("unmasked status without interrupt");

    // bus: exactly one wait state, read data loaded on the first cycle
    AST_ONE_WAIT: assert property (
        req && !st_q.ack |-> AVS_WAITREQUEST)
        else $error("wait state missing");

    AST_WAIT_ONLY_REQ: assert property (
        !req |-> !AVS_WAITREQUEST)
        else $error("stall raised without request");

    AST_ACK_DROPS: assert property (
        take |=> !st_q.ack)
        else $error("acknowledge held after take");

    AST_ACK_ONLY_REQ: assert property (
        !req |=> !st_q.ack)
        else $error("acknowledge without request");

    AST_READ_LIVE: assert property (
        AVS_READ && !st_q.ack && AVS_ADDRESS == mfa_pkg::OFS_LIVE && !rst_now
        |=> AVS_READDATA == {24'h000000, $past(live)})
        else $error("live word read wrong");

    AST_READ_STAT: assert property (
        AVS_READ && !st_q.ack && hit_stat && !rst_now
        |=> AVS_READDATA == {28'h0000000, $past(st_q.irq_stat)})
        else $error("status word read wrong");

    AST_READ_MASK: assert property (
        AVS_READ && !st_q.ack && hit_mask && !rst_now
        |=> AVS_READDATA == {28'h0000000, $past(st_q.irq_mask)})
        else $error("mask word read wrong");

    AST_READ_ZERO: assert property (
        AVS_READ && !st_q.ack && (hit_ctrl || AVS_ADDRESS[1:0] != 2'h0)
        |=> AVS_READDATA == 32'h00000000)
        else $error("unmapped or control read not zero");

    // read data stand until the next request loads them
    AST_RDATA_HOLDS: assert property (
        !(req && !st_q.ack) && !rst_now |=> $stable(AVS_READDATA))
        else $error("read data moved without request");

    AST_MASK_WRITE: assert property (
        wr_take && hit_mask && !rst_now |=> st_q.irq_mask == $past(AVS_WRITEDATA[3:0]))
        else $error("mask write lost");

    AST_BE_IGNORED: assert property (
        take && AVS_WRITE && !AVS_BYTEENABLE[0] && !rst_now |=> $stable(st_q.irq_mask))
        else $error("write without byte lane 0 took effect");

    // interrupt status: a set landing with a clear must win
    AST_STAT_SET_WINS: assert property (
        (|irq_evt) && !rst_now |=> (st_q.irq_stat & $past(irq_evt)) == $past(irq_evt))
        else $error("status event lost");

    AST_STAT_W1C: assert property (
        wr_take && hit_stat && !rst_now |=> (st_q.irq_stat & $past(irq_clr & ~irq_evt)) == 4'h0)
        else $error("status bit not cleared");

    AST_STAT_HOLDS: assert property (
        !(wr_take && hit_stat) && !rst_now
        |=> (st_q.irq_stat & $past(st_q.irq_stat)) == $past(st_q.irq_stat))
        else $error("status bit cleared without write");

    AST_NO_SPURIOUS_SET: assert property (
        !(|irq_evt) && !rst_now |=> (st_q.irq_stat & ~$past(st_q.irq_stat)) == 4'h0)
        else $error("status bit set without event");

    AST_IRQ_QUIET: assert property (
        !(|(st_q.irq_stat & st_q.irq_mask)) |=> !IRQ)
        else $error("interrupt without unmasked status");

    AST_PKT_SET_WINS: assert property (
        PACKET_CHECK_ERR && !rst_now |=> st_q.pkt_err)
        else $error("packet check error lost");

    AST_PKT_CLEAR: assert property (
        pkt_clr && !PACKET_CHECK_ERR && !rst_now |=> !st_q.pkt_err)
        else $error("packet check error not cleared");

    // alerts and mode
    AST_EARLY_RELEASE: assert property (
        !st_q.mode_valid |=> !FAULT_ALERT_OE && !OPEN_CIRCUIT_ALERT_N_OE)
        else $error("alert pulled before mode known");

    AST_HW_SHORT_IGNORED: assert property (
        st_q.mode_valid && st_q.hw_mode && !st_q.flt_s2[mfa_pkg::FLT_TEMP_IDX] && !rst_now |=> !FAULT_ALERT_OE)
        else $error("hardware shared alert pulled without overtemp");

    AST_OC_NEEDS_OPEN: assert property (
        !st_q.flt_s2[mfa_pkg::FLT_OPEN_IDX] |=> !OPEN_CIRCUIT_ALERT_N_OE)
        else $error("open circuit pin pulled without open fault");

    AST_MODE_HELD: assert property (
        st_q.mode_valid && !rst_now |=> st_q.mode_valid && $stable(st_q.hw_mode))
        else $error("control mode changed without reset");

    AST_SETTLE_COUNT: assert property (
        !st_q.mode_valid && st_q.settle_cnt != mfa_pkg::STRAP_SETTLE_CYC && !rst_now
        |=> !st_q.mode_valid && st_q.settle_cnt == $past(st_q.settle_cnt) + 2'h1)
        else $error("strap settle count skipped");

    COV_SW_FAULT: cover property (
        st_q.mode_valid && !st_q.hw_mode ##1 FAULT_ALERT_OE);
    COV_HW_OPEN:  cover property (
        st_q.mode_valid && st_q.hw_mode ##1 OPEN_CIRCUIT_ALERT_N_OE);
    COV_PKT_IRQ:  cover property (
        PACKET_CHECK_ERR ##[1:4] IRQ);
    COV_PIN_RST:  cover property (
        st_q.mode_valid ##1 part_rst);
    COV_BE_DROP:  cover property (
        take && AVS_WRITE && !AVS_BYTEENABLE[0]);

endmodule

`default_nettype wire

// [sim/mfa_host.sv]
`timescale 1ns/1ps
`default_nettype none

module mfa_host (
    input  wire logic fault_o,    // device drive value
    input  wire logic fault_oe,   // device pull enable
    input  wire logic oc_o,       // device drive value
    input  wire logic oc_oe,      // device pull enable
    input  wire logic reset_req,  // bench asks for a part reset
    output logic      fault_n,    // shared alert wire
    output logic      oc_n,       // open-circuit alert wire
    output logic      part_rst_n  // reset pin drive
);
    // pull-ups hold the wires high whenever the device lets go
    assign fault_n    = fault_oe ? fault_o : 1'b1;
    assign oc_n       = oc_oe ? oc_o : 1'b1;
    assign part_rst_n = !reset_req;
endmodule

`default_nettype wire

// [sim/test_mfa_alerts.sv]
`timescale 1ns/1ps
`default_nettype none

module test_mfa_alerts;
    logic        clk, nrst, strap, pkt, rd, wr, rst_req, wait_req, irq;
    logic        f_o, f_oe, oc_o, oc_oe, fault_n, oc_n, part_rst_n;
    logic [2:0]  det, e_f;
    logic [3:0]  adr, be, e_stat, e_mask;
    logic [31:0] wdat, rdat;
    logic [34:0] notes[$];
    logic [34:0] got;
    logic        e_pkt, e_hw;
    int          failures, comparisons, cycles, i;
    integer      seed;

    mfa_alerts i_mfa_alerts (.CLK_SYS(clk), .NRST(nrst), .CONTROL_MODE_STRAP(strap), .PART_RESET_N(part_rst_n),
        .FAULT_DET(det), .PACKET_CHECK_ERR(pkt), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
        .IRQ(irq), .FAULT_ALERT_O(f_o), .FAULT_ALERT_OE(f_oe), .OPEN_CIRCUIT_ALERT_N_O(oc_o),
        .OPEN_CIRCUIT_ALERT_N_OE(oc_oe));
    mfa_host i_mfa_host (.fault_o(f_o), .fault_oe(f_oe), .oc_o(oc_o), .oc_oe(oc_oe), .reset_req(rst_req),
        .fault_n(fault_n), .oc_n(oc_n), .part_rst_n(part_rst_n));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // irq and both wire levels ride along with every read
    function automatic logic [34:0] expect_word(input logic live, input logic [31:0] v);
        logic fo, oc;
        fo = e_hw ? e_f[2] : (|e_f || e_pkt);
        oc = e_hw && e_f[0];
        if (live) v = {24'h0, oc, fo, 1'b1, e_hw, e_pkt, e_f};
        return {|(e_stat & e_mask), !oc, !fo, v};
    endfunction

    task automatic print_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [34:0] e);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        if (!w) notes.push_back(e);
        do @(posedge clk); while (wait_req);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic live, input logic [3:0] a, input logic [31:0] v);
        bus(1'b0, a, 32'h0, expect_word(live, v));
    endtask

    task automatic set_f(input logic [2:0] nf);
        e_stat[2:0] = e_stat[2:0] | (nf & ~e_f);
        e_f = nf;
        det <= nf;
        repeat (6) @(posedge clk);
    endtask

    task automatic pkt_pulse();
        pkt <= 1'b1;
        @(posedge clk);
        pkt <= 1'b0;
        repeat (4) @(posedge clk);
        e_pkt = 1'b1;
        e_stat[3] = 1'b1;
    endtask

    task automatic part_reset(input logic hw);
        strap <= hw;
        rst_req <= 1'b1;
        repeat (4) @(posedge clk);
        rst_req <= 1'b0;
        repeat (8) @(posedge clk);
        {e_stat, e_mask, e_pkt, e_hw} = {9'h000, hw};
    endtask

    always @(posedge clk) begin
        if (rd && !wait_req) begin
            got = {irq, oc_n, fault_n, rdat};
            comparisons++;
            if (got !== notes[0]) begin
                failures++;
                $display("unexpected at %0t: got %h expected %h", $time, got, notes[0]);
            end
            void'(notes.pop_front());
        end
        cycles++;
        // the whole sequence needs well under a thousand cycles
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        seed = 32'h1455b8ef;
        {nrst, strap, pkt, rd, wr, rst_req, det, adr, wdat} <= '0;
        be <= 4'hF;
        {e_f, e_stat, e_mask, e_pkt, e_hw} = '0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        rd_chk(1'b0, mfa_pkg::OFS_IRQ_MASK, 32'h0);
        // a write without byte lane 0 must leave the mask alone
        be <= 4'hE;
        bus(1'b1, mfa_pkg::OFS_IRQ_MASK, 32'h0000000F, '0);
        be <= 4'hF;
        rd_chk(1'b0, mfa_pkg::OFS_IRQ_MASK, 32'h0);
        for (i = 0; i < 8; i++) begin
            set_f(i[2:0]);
            rd_chk(1'b1, mfa_pkg::OFS_LIVE, 32'h0);
        end
        set_f(3'h0);
        pkt_pulse();
        rd_chk(1'b1, mfa_pkg::OFS_LIVE, 32'h0);
        rd_chk(1'b0, mfa_pkg::OFS_IRQ_STAT, {28'h0, e_stat});
        bus(1'b1, mfa_pkg::OFS_IRQ_MASK, 32'h0000000F, '0);
        e_mask = 4'hF;
        rd_chk(1'b0, mfa_pkg::OFS_IRQ_STAT, {28'h0, e_stat});
        bus(1'b1, mfa_pkg::OFS_IRQ_STAT, 32'h00000007, '0);
        e_stat[2:0] = 3'h0;
        rd_chk(1'b0, mfa_pkg::OFS_IRQ_STAT, {28'h0, e_stat});
        bus(1'b1, mfa_pkg::OFS_CTRL, 32'h00000001, '0);
        e_pkt = 1'b0;
        rd_chk(1'b1, mfa_pkg::OFS_LIVE, 32'h0);
        rd_chk(1'b0, 4'h2, 32'h0);
        rd_chk(1'b0, mfa_pkg::OFS_CTRL, 32'h0);
        // soft reset with a pending packet error and the mask open
        pkt_pulse();
        bus(1'b1, mfa_pkg::OFS_CTRL, 32'h00000002, '0);
        {e_stat, e_mask, e_pkt} = '0;
        repeat (8) @(posedge clk);
        rd_chk(1'b1, mfa_pkg::OFS_LIVE, 32'h0);
        rd_chk(1'b0, mfa_pkg::OFS_IRQ_MASK, 32'h0);
        part_reset(1'b1);
        for (i = 0; i < 8; i++) begin
            set_f(3'($random(seed)));
            rd_chk(1'b1, mfa_pkg::OFS_LIVE, 32'h0);
        end
        set_f(3'h0);
        pkt_pulse();
        rd_chk(1'b1, mfa_pkg::OFS_LIVE, 32'h0);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        {e_stat, e_mask, e_pkt} = '0;
        rd_chk(1'b1, mfa_pkg::OFS_LIVE, 32'h0);
        print_verdict();
    end
endmodule

`default_nettype wire
